// *** rtl/link_debug_params.svh ***
// Offsets, field positions, reset values and codes of the link training debug bus.
`ifndef LINK_DEBUG_PARAMS_SVH
`define LINK_DEBUG_PARAMS_SVH

// Observation bus layout.
`define OBS_WIDTH 48
`define LANE_COUNT 8

// Training state codes of interest.
`define LTSSM_DETECT_QUIET 5'h00
`define LTSSM_UNUSED_CODE 5'h05
`define LTSSM_L0 5'h0f
`define LTSSM_LAST_CODE 5'h19

// Highest legal transmit low-power sub-state code.
`define TX_SUB_LAST_CODE 3'h4

// Wishbone register byte offsets.
`define REG_STATUS 8'h00
`define REG_MASK 8'h04
`define REG_TARGET 8'h08
`define REG_OBS_LO 8'h0c
`define REG_OBS_HI 8'h10
`define REG_LANE_INIT 8'h14

// Event bit positions in the status and mask registers.
`define EV_STATE_CHANGE 0
`define EV_TIMEOUT 1
`define EV_PLP_SENT 2
`define EV_TARGET_HIT 3
`define EV_COUNT 4

// Reset values.
`define STATUS_RESET 4'h0
`define MASK_RESET 4'h0
`define TARGET_RESET 5'h0f

`endif

// *** rtl/link_debug_pkg.sv ***
// Types shared by the link training debug bus design.
package link_debug_pkg;

  // Training state codes; code 5'h05 is never presented.
  typedef enum logic [4:0] {
    ST_DETECT_QUIET = 5'b00000, ST_DETECT_ACTIVE = 5'b00001, ST_POLL_ACTIVE = 5'b00010,
    ST_POLL_COMPLIANCE = 5'b00011, ST_POLL_CONFIG = 5'b00100, ST_CFG_WIDTH_START = 5'b00110,
    ST_CFG_WIDTH_ACCEPT = 5'b00111, ST_CFG_LANE_ACCEPT = 5'b01000,
    ST_CFG_LANE_WAIT = 5'b01001, ST_CFG_COMPLETE = 5'b01010, ST_CFG_IDLE = 5'b01011,
    ST_REC_LOCK = 5'b01100, ST_REC_CONFIG = 5'b01101, ST_REC_IDLE = 5'b01110,
    ST_L0 = 5'b01111, ST_DISABLE = 5'b10000, ST_LOOP_ENTRY = 5'b10001,
    ST_LOOP_ACTIVE = 5'b10010, ST_LOOP_EXIT = 5'b10011, ST_HOT_RESET = 5'b10100,
    ST_L0S = 5'b10101, ST_L1_ENTRY = 5'b10110, ST_L1_IDLE = 5'b10111,
    ST_L2_IDLE = 5'b11000, ST_L2_TX_WAKE = 5'b11001
  } ltssm_state_t;

  typedef enum logic [1:0] {
    RX_INACTIVE = 2'b00, RX_IDLE = 2'b01, RX_FTS = 2'b10, RX_TO_RECOVERY = 2'b11
  } rx_low_power_substate_t;

  typedef enum logic [2:0] {
    TX_INACTIVE = 3'b000, TX_ENTRY = 3'b001, TX_IDLE = 3'b010, TX_FTS = 3'b011,
    TX_TO_L0 = 3'b100
  } tx_low_power_substate_t;

  typedef enum logic [2:0] {
    PLP_ELEC_IDLE = 3'b000, PLP_RX_DETECT = 3'b001, PLP_TS1 = 3'b010, PLP_TS2 = 3'b011,
    PLP_IDLE_DATA = 3'b100, PLP_FTS = 3'b101, PLP_IDL = 3'b110, PLP_COMPLIANCE = 3'b111
  } plp_type_t;

  // Lower 32 observation bits, most significant field first.
  typedef struct packed {
    logic [7:0] pad_force;
    logic [7:0] rx_detect;
    plp_type_t plp_type;
    logic plp_sent;
    logic tx_exit_done;
    logic timeout;
    tx_low_power_substate_t tx_low_power_substate;
    rx_low_power_substate_t rx_low_power_substate;
    ltssm_state_t state;
  } obs_core_t;

  // Classic Wishbone request from the master.
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

  // State of the debug bus top, apart from the training-set flags.
  typedef struct packed {
    obs_core_t obs;
    logic sent_prev;
    logic [3:0] status;
    logic [3:0] mask;
    logic [4:0] target;
    logic [7:0] lane_init;
    logic ack;
    logic [31:0] rdat;
  } debug_state_t;

endpackage

// *** rtl/lane_flag_bank.sv ***
// Per-lane sticky flags with a common clear, set winning over clear.
`timescale 1ns/1ps
module lane_flag_bank import link_debug_pkg::*; (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] set_in,
  input wire logic clear_all_in,
  output logic [7:0] flags_out
);

  logic [7:0] flags_q;
  logic [7:0] flags_d;

  // Each lane keeps its flag until a clear, and an arrival in the clearing
  // cycle survives so a set-up sequence seen on entry is not lost.
  for (genvar i = 0; i < 8; i++) begin : g_lane
    always_comb begin
      if (set_in[i]) begin
        flags_d[i] = 1'b1;
      end else if (clear_all_in) begin
        flags_d[i] = 1'b0;
      end else begin
        flags_d[i] = flags_q[i];
      end
    end
  end

  // Flag register.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      flags_q <= 8'h00;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign flags_out = flags_q;

endmodule

// *** rtl/link_training_debug_bus.sv ***
// Debug observation bus, bits 47:0, of the link training logic with a Wishbone view.
// Functional notes
// - Bits 4:0 show legal training state code.
// - Bits 6:5 show receive low-power sub-state.
// - Bits 9:7 show transmit low-power sub-state.
// - Bit 10 flags current state timeout reached.
// - Bit 11 flags transmit exit condition complete.
// - Bit 12 pulses one cycle per sent packet.
// - Bits 15:13 carry requested physical packet type.
// - Bits 23:16 carry per-lane receiver detect result.
// - Bits 31:24 show per-lane forced pad transmission.
// - Pad-forced lanes are excluded from initialization.
// - Bits 39:32 first training set seen, cleared.
// - Bits 47:40 second training set seen, cleared.
//
// The Wishbone register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "link_debug_params.svh"
module link_training_debug_bus import link_debug_pkg::*; (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [4:0] ltssm_state_in,
  input wire logic [1:0] rx_low_power_substate_in,
  input wire logic [2:0] tx_low_power_substate_in,
  input wire logic timeout_in,
  input wire logic tx_exit_done_in,
  input wire logic plp_sent_in,
  input wire logic [2:0] plp_type_in,
  input wire logic [7:0] rx_detect_in,
  input wire logic [7:0] pad_force_in,
  input wire logic [7:0] lane_first_training_set_seen_in,
  input wire logic [7:0] lane_second_training_set_seen_in,
  input wire wb_req_t wb_in,
  output logic wb_ack_out,
  output logic [31:0] wb_dat_out,
  output logic [47:0] test_bus_out,
  output logic [7:0] lane_init_enable_out,
  output logic irq_out
);

  debug_state_t s_q;
  debug_state_t s_d;
  logic [7:0] ts1_flags;
  logic [7:0] ts2_flags;
  logic state_valid;
  logic state_change;
  logic tx_sub_valid;
  logic req;
  logic wr_now;
  logic [3:0] events;
  logic [3:0] w1c;

  // Returns true for a code that names a real training state.
  function automatic logic legal_state(input logic [4:0] code);
    legal_state = (code <= `LTSSM_LAST_CODE) && (code != `LTSSM_UNUSED_CODE);
  endfunction

  // Address match helper, used for every register decode.
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    hit = (adr == off);
  endfunction

  // A bad code from the source is not passed on: the last legal one stands,
  // so a glitching source never shows the unused code on the bus.
  assign state_valid = legal_state(ltssm_state_in);
  assign state_change = state_valid && (ltssm_state_in != s_q.obs.state);
  assign tx_sub_valid = (tx_low_power_substate_in <= `TX_SUB_LAST_CODE);

  // Bus request seen and the write edge is the one where ack is high.
  assign req = wb_in.cyc && wb_in.stb;
  assign wr_now = req && wb_in.we && s_q.ack;

  // Events that set the sticky status bits.
  always_comb begin
    events = 4'h0;
    events[`EV_STATE_CHANGE] = state_change;
    events[`EV_TIMEOUT] = timeout_in && !s_q.obs.timeout;
    events[`EV_PLP_SENT] = plp_sent_in && !s_q.sent_prev;
    events[`EV_TARGET_HIT] = state_change && (ltssm_state_in == s_q.target);
  end

  // Write-one-to-clear mask, only on the low byte lane.
  always_comb begin
    w1c = 4'h0;
    if (wr_now && wb_in.sel[0] && hit(wb_in.adr, `REG_STATUS)) begin
      w1c = wb_in.dat[3:0];
    end
  end

  // Training-set seen flags, cleared whenever a new state is entered.
  lane_flag_bank u_ts1_flags (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .set_in(lane_first_training_set_seen_in),
    .clear_all_in(state_change),
    .flags_out(ts1_flags)
  );

  lane_flag_bank u_ts2_flags (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .set_in(lane_second_training_set_seen_in),
    .clear_all_in(state_change),
    .flags_out(ts2_flags)
  );

  // Next-state logic for the block, apart from the training-set flags.
  always_comb begin
    s_d = s_q;

    // Observation fields are sampled every cycle, except illegal state and tx sub-state codes, which are held.
    if (state_valid) begin
      s_d.obs.state = ltssm_state_t'(ltssm_state_in);
    end
    s_d.obs.rx_low_power_substate = rx_low_power_substate_t'(rx_low_power_substate_in);
    if (tx_sub_valid) begin
      s_d.obs.tx_low_power_substate = tx_low_power_substate_t'(tx_low_power_substate_in);
    end
    s_d.obs.timeout = timeout_in;
    s_d.obs.tx_exit_done = tx_exit_done_in;
    // A held sent input still pulses only once, on its rising edge.
    s_d.obs.plp_sent = plp_sent_in && !s_q.sent_prev;
    s_d.sent_prev = plp_sent_in;
    s_d.obs.plp_type = plp_type_t'(plp_type_in);
    s_d.obs.rx_detect = rx_detect_in;
    s_d.obs.pad_force = pad_force_in;

    // A lane forced to pad stays out of initialization.
    s_d.lane_init = ~pad_force_in;

    // Sticky status: a new event wins over a clear in the same cycle.
    s_d.status = (s_q.status & ~w1c) | events;

    // Register writes land on the edge where ack is seen high.
    if (wr_now && wb_in.sel[0]) begin
      if (hit(wb_in.adr, `REG_MASK)) begin
        s_d.mask = wb_in.dat[3:0];
      end else if (hit(wb_in.adr, `REG_TARGET)) begin
        s_d.target = wb_in.dat[4:0];
      end
    end

    // One-cycle ack; it drops in the cycle after it was given.
    s_d.ack = req && !s_q.ack;

    // Read data is registered together with the ack.
    s_d.rdat = 32'h0000_0000;
    if (req && !s_q.ack && !wb_in.we) begin
      if (hit(wb_in.adr, `REG_STATUS)) begin
        s_d.rdat = {28'h000_0000, s_q.status};
      end else if (hit(wb_in.adr, `REG_MASK)) begin
        s_d.rdat = {28'h000_0000, s_q.mask};
      end else if (hit(wb_in.adr, `REG_TARGET)) begin
        s_d.rdat = {27'h000_0000, s_q.target};
      end else if (hit(wb_in.adr, `REG_OBS_LO)) begin
        s_d.rdat = s_q.obs;
      end else if (hit(wb_in.adr, `REG_OBS_HI)) begin
        s_d.rdat = {16'h0000, ts2_flags, ts1_flags};
      end else if (hit(wb_in.adr, `REG_LANE_INIT)) begin
        s_d.rdat = {24'h00_0000, s_q.lane_init};
      end else begin
        s_d.rdat = 32'h0000_0000;
      end
    end
  end

  // State register; the reset shows detect-quiet and all flags clear.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      s_q <= '0;
      s_q.status <= `STATUS_RESET;
      s_q.mask <= `MASK_RESET;
      s_q.target <= `TARGET_RESET;
      s_q.lane_init <= 8'hff;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flip-flops; only lane_init_enable_out feeds back to the link.
  assign test_bus_out = {ts2_flags, ts1_flags, s_q.obs};
  assign lane_init_enable_out = s_q.lane_init;
  assign wb_ack_out = s_q.ack;
  assign wb_dat_out = s_q.rdat;

  // Level interrupt while any unmasked status bit stands.
  assign irq_out = |(s_q.status & s_q.mask);

endmodule

// *** sim/link_debug_checker.sv ***
// Port-level assertions for the link training debug bus.
`timescale 1ns/1ps
module link_debug_checker (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [4:0] ltssm_state_in,
  input wire logic [1:0] rx_low_power_substate_in,
  input wire logic [2:0] tx_low_power_substate_in,
  input wire logic timeout_in,
  input wire logic tx_exit_done_in,
  input wire logic plp_sent_in,
  input wire logic [2:0] plp_type_in,
  input wire logic [7:0] rx_detect_in,
  input wire logic [7:0] pad_force_in,
  input wire logic [7:0] lane_first_training_set_seen_in,
  input wire logic [7:0] lane_second_training_set_seen_in,
  input wire logic wb_ack_out,
  input wire logic [47:0] test_bus_out,
  input wire logic [7:0] lane_init_enable_out
);
  // Short aliases keep the properties readable.
  wire [7:0] ts1 = lane_first_training_set_seen_in;
  wire [7:0] ts2 = lane_second_training_set_seen_in;
  wire [47:0] bus = test_bus_out;
  wire legal = ltssm_state_in != 5'h05 && ltssm_state_in <= 5'h19;
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  a_state_legal: assert property (bus[4:0] != 5'h05 && bus[4:0] <= 5'h19)
    else $error("illegal state code shown");
  a_state_copy: assert property (legal |=> bus[4:0] == $past(ltssm_state_in))
    else $error("state code not followed");
  a_tx_copy: assert property (tx_low_power_substate_in <= 3'h4 |=>
    bus[9:7] == $past(tx_low_power_substate_in)) else $error("tx sub-state not followed");
  a_level_copy: assert property (1'b1 |=> {bus[31:13], bus[11:10], bus[6:5]} ==
    {$past(pad_force_in), $past(rx_detect_in), $past(plp_type_in), $past(tx_exit_done_in),
    $past(timeout_in), $past(rx_low_power_substate_in)}) else $error("level field wrong");
  a_sent_pulse: assert property ($rose(plp_sent_in) |=> bus[12] ##1 !bus[12])
    else $error("sent pulse not one cycle");
  a_sent_cause: assert property (bus[12] |-> $past(plp_sent_in) && !$past(plp_sent_in, 2))
    else $error("sent pulse without new packet");
  a_lane_excl: assert property (1'b1 |=> lane_init_enable_out == ~$past(pad_force_in))
    else $error("padded lane not excluded");
  a_ts_sticky: assert property (1'b1 |=> (bus[47:32] & {$past(ts2), $past(ts1)}) ==
    {$past(ts2), $past(ts1)}) else $error("training set arrival lost");
  a_ts_clear: assert property (legal && ltssm_state_in != bus[4:0] |=>
    bus[47:32] == {$past(ts2), $past(ts1)}) else $error("flags not cleared on new state");
  a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack longer than one cycle");
  c_sent: cover property ($rose(plp_sent_in) ##1 bus[12]);
  c_state: cover property (legal && ltssm_state_in != bus[4:0]);
  c_ack: cover property (wb_ack_out);
endmodule
bind link_training_debug_bus link_debug_checker chk_i (.*);

// *** sim/link_core_model.sv ***
// Stand-in for the link training logic that feeds the debug bus.
`timescale 1ns/1ps
module link_core_model import link_debug_pkg::*; (
  input wire logic clk_in,
  input wire logic run_in,
  input wire logic bad_in,
  output obs_core_t core_out = '0,
  output logic [7:0] ts1_out = '0,
  output logic [7:0] ts2_out = '0
);
  logic [31:0] r;
  logic [31:0] t;
  bit seeded = 1'b0;
  // Fresh levels each cycle; the state moves only now and then so flags can pile up.
  // The generator of this process is seeded once, at the first edge, before any test runs.
  always @(posedge clk_in) begin
    if (!seeded) begin
      void'($urandom(32'hbd98fb32));
      seeded = 1'b1;
    end
    if (run_in) begin
      r = $urandom;
      t = $urandom;
      if (r[31:30] != 2'b00) r[4:0] = core_out.state;
      if (!bad_in && (r[4:0] == 5'h05 || r[4:0] > 5'h19)) r[4:0] = 5'h0f;
      if (!bad_in && r[9:7] > 3'h4) r[9:7] = 3'h0;
      core_out <= obs_core_t'(r);
      ts1_out <= t[7:0] & t[15:8];
      ts2_out <= t[23:16] & t[31:24];
    end
  end
endmodule

// *** sim/tb_top.sv ***
// Self-checking bench of the link training debug bus.
`timescale 1ns/1ps
module tb_top import link_debug_pkg::*;;
  logic clk_in = 0, sys_rst_in = 1, run = 0, bad = 0, prev = 0, wb_ack_out, irq_out;
  obs_core_t core;
  wb_req_t wb = '0;
  logic [7:0] ts1, ts2, lane, e_ts1, e_ts2, e_lane = 8'hff;
  logic [4:0] e_st = 0, e_tgt = 5'h0f;
  logic [3:0] e_stat = 0;
  logic chg = 0;
  logic [2:0] e_tx = 0;
  logic [31:0] wb_dat_out;
  logic [47:0] test_bus_out, rd, e_bus = 0;
  int n_fail = 0, checked = 0, k, n_chg = 0, n0;
  always #20 clk_in = ~clk_in;
  link_core_model core_m (.clk_in(clk_in), .run_in(run), .bad_in(bad), .core_out(core),
    .ts1_out(ts1), .ts2_out(ts2));
  link_training_debug_bus DUT (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .ltssm_state_in(core.state), .rx_low_power_substate_in(core.rx_low_power_substate),
    .tx_low_power_substate_in(core.tx_low_power_substate), .timeout_in(core.timeout),
    .tx_exit_done_in(core.tx_exit_done), .plp_sent_in(core.plp_sent),
    .plp_type_in(core.plp_type), .rx_detect_in(core.rx_detect), .pad_force_in(core.pad_force),
    .lane_first_training_set_seen_in(ts1), .lane_second_training_set_seen_in(ts2),
    .wb_in(wb), .wb_ack_out(wb_ack_out), .wb_dat_out(wb_dat_out),
    .test_bus_out(test_bus_out), .lane_init_enable_out(lane), .irq_out(irq_out));
  task chk(input string nm, input logic [47:0] s, input logic [47:0] e);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value %s exp %h seen %h", nm, e, s);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // One classic cycle; the wait is bounded so a silent slave ends the run.
  task wb_do(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    wb <= '{1'b1, 1'b1, we, a, 4'hf, d};
    for (k = 0; k < 9 && wb_ack_out !== 1'b1; k++) @(posedge clk_in);
    if (k == 9) begin
      n_fail++;
      wrap_up();
    end
    rd = {16'h0, wb_dat_out};
    wb <= '0;
  endtask
  // Reference model: the inputs seen at each edge give the bus after it.
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      e_st = 0; e_tx = 0; e_ts1 = 0; e_ts2 = 0; prev = 0; e_bus = 0; e_lane = 8'hff;
      e_stat = 0;
    end else begin
      chg = core.state != 5'h05 && core.state <= 5'h19 && core.state != e_st;
      // Sticky events: state change, timeout rise, packet sent, target state entered.
      e_stat |= {chg && core.state == e_tgt, core.plp_sent & ~prev, core.timeout & ~e_bus[10],
        chg};
      if (chg) begin
        e_st = core.state; e_ts1 = 0; e_ts2 = 0; n_chg++;
      end
      e_ts1 |= ts1; e_ts2 |= ts2;
      if (core.tx_low_power_substate <= 3'h4) e_tx = core.tx_low_power_substate;
      e_bus = {e_ts2, e_ts1, core.pad_force, core.rx_detect, core.plp_type,
        core.plp_sent & ~prev, core.tx_exit_done, core.timeout, e_tx,
        core.rx_low_power_substate, e_st};
      prev = core.plp_sent; e_lane = ~core.pad_force;
    end
  end
  // Compared mid-cycle, after the registered outputs have settled.
  always @(negedge clk_in) begin
    chk("test_bus", test_bus_out, e_bus);
    chk("lane_init", {40'h0, lane}, {40'h0, e_lane});
    // Read data must be zero whenever no acknowledge stands.
    if (!wb_ack_out) chk("wb_dat_idle", {16'h0, wb_dat_out}, 48'h0);
  end
  initial begin
    repeat (3) @(posedge clk_in);
    sys_rst_in <= 0;
    wb_do(0, 8'h08, 0); chk("target", rd, 48'h0f);
    wb_do(0, 8'h04, 0); chk("mask", rd, 48'h0);
    wb_do(1, 8'h08, 32'h0c);
    e_tgt = 5'h0c;
    wb_do(0, 8'h08, 0); chk("target_wr", rd, 48'h0c);
    $display("reset test done");
    run <= 1; repeat (300) @(posedge clk_in);
    bad <= 1; repeat (300) @(posedge clk_in);
    run <= 0; bad <= 0;
    $display("random test done");
    wb_do(0, 8'h00, 0); chk("status", rd, {44'h0, e_stat});
    wb_do(0, 8'h0c, 0); chk("obs_lo", rd, {16'h0, e_bus[31:0]});
    wb_do(0, 8'h10, 0); chk("obs_hi", rd, {32'h0, e_bus[47:32]});
    wb_do(1, 8'h14, 0); wb_do(0, 8'h14, 0); chk("lane_reg", rd, {40'h0, e_lane});
    wb_do(0, 8'h3c, 0); chk("unmapped", rd, 48'h0);
    wb_do(1, 8'h00, 32'hf);
    e_stat = 0;
    wb_do(0, 8'h00, 0); chk("status_clr", rd, {44'h0, e_stat});
    $display("register test done");
    wb_do(1, 8'h04, 32'h1); n0 = n_chg;
    run <= 1; repeat (8) @(posedge clk_in);
    run <= 0; repeat (3) @(posedge clk_in);
    chk("irq_state", {47'h0, irq_out}, {47'h0, n_chg != n0});
    wb_do(1, 8'h04, 0); repeat (2) @(posedge clk_in);
    chk("irq_masked", {47'h0, irq_out}, 48'h0);
    wb_do(1, 8'h00, 32'h1); wb_do(1, 8'h04, 32'h1); repeat (2) @(posedge clk_in);
    chk("irq_cleared", {47'h0, irq_out}, 48'h0);
    $display("interrupt test done");
    wrap_up();
  end
endmodule
